// file: src/serial_link_cfg_defs.svh
// Purpose: Offsets, field positions, reset values and counts for the link config bank
// Assumes: Printed offsets are register indexes; byte address is four times the index
// Notes:   Included by the register bank only
`ifndef SERIAL_LINK_CFG_DEFS_SVH
`define SERIAL_LINK_CFG_DEFS_SVH

`define IDX_IF_ENABLE        12'h200
`define IDX_MODE_SELECT      12'h201
`define IDX_MULTIFRAME_LEN   12'h202
`define IDX_SOFT_SYNC        12'h203
`define IDX_LINK_CONTROL     12'h204
`define IDX_LINK_TEST        12'h205
`define IDX_LANE_STATUS      12'h210

`define RST_IF_ENABLE        8'h01
`define RST_MODE_SELECT      8'h02
`define RST_MULTIFRAME_LEN   8'h1f
`define RST_SOFT_SYNC        8'h01
`define RST_LINK_CONTROL     8'h03
`define RST_LINK_TEST        8'h00

`define BIT_SCRAMBLER        0
`define BIT_SAMPLE_FORMAT    1
`define SYNC_SEL_LO          2
`define SYNC_SEL_HI          3
`define BIT_UPPER_LANES      4
`define TEST_SEL_HI          4
`define RSVD_CTRL_MASK       8'h1f
`define RSVD_TEST_MASK       8'h1f
`define RSVD_ONE_BIT_MASK    8'h01

`define SYNC_SRC_DEDICATED   2'h0
`define SYNC_SRC_TIMESTAMP   2'h1
`define SYNC_SRC_SOFTWARE    2'h2

`define FRAMES_66B_SCALE     16'h0100
`define LANES_PER_LINK       8
`define HALF_LANES           4
`define ENC_66B_MODE_MIN     8'h14

`endif

// file: src/serial_link_cfg_pkg.sv
// Purpose: Types shared by the link configuration bank
// Assumes: Constants live in the defs header
// Notes:   Types only
package serial_link_cfg_pkg;
  typedef enum logic [1:0] {
    SYNC_DEDICATED,
    SYNC_TIMESTAMP,
    SYNC_SOFTWARE,
    SYNC_RESERVED
  } sync_src_t;

  typedef enum logic {
    FMT_OFFSET_BINARY,
    FMT_TWOS_COMPLEMENT
  } sample_fmt_t;

  typedef enum {
    BUS_IDLE,
    BUS_DONE
  } bus_state_t;
endpackage : serial_link_cfg_pkg

// file: src/serial_link_config_registers.sv
// Purpose: Avalon-MM register bank for the serial link transmitter configuration
// Assumes: Inputs synchronous to clk; one-wait-state slave; encoding, E and F given by mode logic
// Notes:   Multiframe counter and lane enables derived here for the link block
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ps
`include "serial_link_cfg_defs.svh"

module serial_link_config_registers #(
  parameter int ADDR_W = 14
) (
  input  wire logic                          clk,
  input  wire logic                          reset_n,
  input  wire logic [ADDR_W-1:0]             address,
  input  wire logic                          read,
  input  wire logic                          write,
  input  wire logic [31:0]                   writedata,
  input  wire logic [3:0]                    byteenable,
  output logic      [31:0]                   readdata,
  output logic                               waitrequest,
  input  wire logic                          dedicatedSyncInput_n,
  input  wire logic                          timestampInput_n,
  input  wire logic                          timestampReceiverEnable,
  input  wire logic [7:0]                    framesPerMfEncoded,
  output logic                               syncRequest,
  output logic                               scramblerActive,
  output serial_link_cfg_pkg::sample_fmt_t   sampleFormat,
  output logic [4:0]                         linkTestSelect,
  output logic [`LANES_PER_LINK-1:0]         laneEnableA,
  output logic [`LANES_PER_LINK-1:0]         laneEnableB,
  output logic                               linkResetHold,
  output logic [8:0]                         multiframeCount,
  output logic                               multiframeStart,
  output logic                               enc66bActive
);
  import serial_link_cfg_pkg::*;

  bus_state_t  busState_ff;
  logic [7:0]  ifEnable_ff, modeSelect_ff, multiframeLenM1_ff;
  logic [7:0]  softSyncReqN_ff, linkControl_ff, linkTestSel_ff;
  logic [8:0]  mfCount_ff;
  logic        pinSync_ff;

  // Decode: byte address is four times the register index
  wire         access       = read | write;
  wire [11:0]  regIndex     = 12'(address >> 2);
  wire         alignedWord  = (address[1:0] == 2'h0);
  wire         hitEnable    = alignedWord && regIndex == `IDX_IF_ENABLE;
  wire         hitMode      = alignedWord && regIndex == `IDX_MODE_SELECT;
  wire         hitLen       = alignedWord && regIndex == `IDX_MULTIFRAME_LEN;
  wire         hitSync      = alignedWord && regIndex == `IDX_SOFT_SYNC;
  wire         hitCtrl      = alignedWord && regIndex == `IDX_LINK_CONTROL;
  wire         hitTest      = alignedWord && regIndex == `IDX_LINK_TEST;
  wire         hitStatus    = alignedWord && regIndex == `IDX_LANE_STATUS;
  // Write lands at the edge where the master sees waitrequest low
  wire         doWrite      = write && busState_ff == BUS_DONE && byteenable[0];
  wire [7:0]   wByte        = writedata[7:0];

  // Field views
  wire         ifEnabled    = ifEnable_ff[0];
  wire         enc66b       = (modeSelect_ff >= `ENC_66B_MODE_MIN);
  wire         upperLanes   = linkControl_ff[`BIT_UPPER_LANES];
  wire [1:0]   syncSel      = linkControl_ff[`SYNC_SEL_HI:`SYNC_SEL_LO];

  // Sync source: software bit always ORs in; pins active low
  logic pinReq;
  always_comb begin
    unique case (syncSel)
      `SYNC_SRC_DEDICATED: pinReq = ~dedicatedSyncInput_n;
      `SYNC_SRC_TIMESTAMP: pinReq = ~timestampInput_n & timestampReceiverEnable;
      `SYNC_SRC_SOFTWARE:  pinReq = 1'b0;
      default:             pinReq = 1'b0;
    endcase
  end
  wire softReq = ~softSyncReqN_ff[0];

  // Multiframe length: 8b/10b from register, 64b/66b from mode
  wire [8:0] lenM1Reg = {1'b0, multiframeLenM1_ff};
  // An encoded zero stands for 256 frames
  wire [8:0] lenM1Enc = (framesPerMfEncoded == 8'h00) ? 9'h0ff
                        : 9'(framesPerMfEncoded) - 9'h001;
  wire [8:0] lenM1    = enc66b ? lenM1Enc : lenM1Reg;
  wire       mfWrap   = (mfCount_ff >= lenM1);
  wire [8:0] nxt_mfCount = !ifEnabled ? 9'h000 : (mfWrap ? 9'h000 : mfCount_ff + 9'h001);

  // Lane enables per link: one generate loop over lanes
  logic [`LANES_PER_LINK-1:0] nxt_laneEn;
  genvar lane;
  generate
    for (lane = 0; lane < `LANES_PER_LINK; lane++) begin : g_lane
      localparam bit UPPER = (lane >= `HALF_LANES);
      assign nxt_laneEn[lane] = ifEnabled && (UPPER ? upperLanes : !upperLanes);
    end
  endgenerate

  // Read mux; unmapped addresses read zero
  logic [7:0] readByte;
  always_comb begin
    readByte = 8'h00;
    if (hitEnable) readByte = ifEnable_ff;
    if (hitMode)   readByte = modeSelect_ff;
    if (hitLen)    readByte = multiframeLenM1_ff;
    if (hitSync)   readByte = softSyncReqN_ff & `RSVD_ONE_BIT_MASK;
    if (hitCtrl)   readByte = linkControl_ff & `RSVD_CTRL_MASK;
    if (hitTest)   readByte = linkTestSel_ff & `RSVD_TEST_MASK;
    if (hitStatus) readByte = {syncRequest, enc66b, pinSync_ff, 5'h00};
  end

  // Bus: every access takes exactly one wait state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busState_ff <= BUS_IDLE;
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
    end else begin
      busState_ff <= (access && busState_ff == BUS_IDLE) ? BUS_DONE : BUS_IDLE;
      waitrequest <= !(access && busState_ff == BUS_IDLE);
      readdata    <= {24'h00_0000, readByte};
    end
  end

  // Registers; the far side keeps reserved bits zero and writes only while disabled
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ifEnable_ff        <= `RST_IF_ENABLE;
      modeSelect_ff      <= `RST_MODE_SELECT;
      multiframeLenM1_ff <= `RST_MULTIFRAME_LEN;
      softSyncReqN_ff    <= `RST_SOFT_SYNC;
      linkControl_ff     <= `RST_LINK_CONTROL;
      linkTestSel_ff     <= `RST_LINK_TEST;
    end else if (doWrite) begin
      if (hitEnable) ifEnable_ff        <= wByte & `RSVD_ONE_BIT_MASK;
      if (hitMode)   modeSelect_ff      <= wByte;
      if (hitLen)    multiframeLenM1_ff <= wByte;
      if (hitSync)   softSyncReqN_ff    <= wByte & `RSVD_ONE_BIT_MASK;
      if (hitCtrl)   linkControl_ff     <= wByte & `RSVD_CTRL_MASK;
      if (hitTest)   linkTestSel_ff     <= wByte & `RSVD_TEST_MASK;
    end
  end

  // Outputs, all registered
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pinSync_ff      <= 1'b0;
      syncRequest     <= 1'b0;
      scramblerActive <= 1'b0;
      sampleFormat    <= FMT_TWOS_COMPLEMENT;
      linkTestSelect  <= 5'h00;
      laneEnableA     <= '0;
      laneEnableB     <= '0;
      linkResetHold   <= 1'b1;
      mfCount_ff      <= 9'h000;
      multiframeCount <= 9'h000;
      multiframeStart <= 1'b0;
      enc66bActive    <= 1'b0;
    end else begin
      pinSync_ff      <= pinReq;
      syncRequest     <= ifEnabled && (softReq || pinReq);
      scramblerActive <= ifEnabled && (enc66b || linkControl_ff[`BIT_SCRAMBLER]);
      sampleFormat    <= sample_fmt_t'(linkControl_ff[`BIT_SAMPLE_FORMAT]);
      linkTestSelect  <= ifEnabled ? linkTestSel_ff[`TEST_SEL_HI:0] : 5'h00;
      laneEnableA     <= nxt_laneEn;
      laneEnableB     <= nxt_laneEn;
      linkResetHold   <= !ifEnabled;
      mfCount_ff      <= nxt_mfCount;
      multiframeCount <= nxt_mfCount;
      multiframeStart <= ifEnabled && nxt_mfCount == 9'h000;
      enc66bActive    <= enc66b;
    end
  end
endmodule : serial_link_config_registers

// file: sim/serial_link_cfg_chk.sv
// Purpose: Port assertions for the link config bank
// Assumes: One clock domain, async active-low reset
// Notes:   Derived outputs are registered, so they are checked against each other
`timescale 1ns/1ps
module serial_link_cfg_chk (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        syncRequest,
  input wire logic        scramblerActive,
  input wire logic [7:0]  laneEnableA,
  input wire logic [7:0]  laneEnableB,
  input wire logic        linkResetHold,
  input wire logic [8:0]  multiframeCount,
  input wire logic [4:0]  linkTestSelect,
  input wire logic        enc66bActive
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_wait_one_state: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("no answer one cycle after request");
  a_wait_pulse: assert property (!waitrequest |=> waitrequest)
    else $error("answer longer than one cycle");
  a_read_upper_zero: assert property (!waitrequest |-> readdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_hold_link_idle: assert property (linkResetHold |-> laneEnableA == 8'h0 &&
    laneEnableB == 8'h0 && multiframeCount == 9'h0 && linkTestSelect == 5'h0)
    else $error("link not held while disabled");
  a_nosync_off: assert property (linkResetHold |-> !syncRequest)
    else $error("sync request while disabled");
  a_lanes_half: assert property (!linkResetHold |-> laneEnableA == laneEnableB &&
    (laneEnableA == 8'h0f || laneEnableA == 8'hf0))
    else $error("lane enables not one half");
  a_scr_66b: assert property (enc66bActive && !linkResetHold |-> scramblerActive)
    else $error("64b/66b mode without scrambling");
  a_frame_step: assert property (!linkResetHold |=>
    multiframeCount == $past(multiframeCount) + 9'h1 || multiframeCount == 9'h0)
    else $error("frame counter skipped");
  c_write_done: cover property (write && !waitrequest);
  c_sync_seen: cover property (syncRequest);
  c_upper_lanes: cover property (laneEnableA == 8'hf0);
endmodule : serial_link_cfg_chk

bind serial_link_config_registers serial_link_cfg_chk chk_u (.clk(clk), .reset_n(reset_n),
  .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest),
  .syncRequest(syncRequest), .scramblerActive(scramblerActive), .laneEnableA(laneEnableA),
  .laneEnableB(laneEnableB), .linkResetHold(linkResetHold), .multiframeCount(multiframeCount),
  .linkTestSelect(linkTestSelect), .enc66bActive(enc66bActive));

// file: sim/sync_rx_model.sv
// Purpose: Far-side receiver driving the active-low sync pins
// Assumes: Receiver logic runs on the device clock
// Notes:   Pins idle high; a stuck-low pin is just a request held on
`timescale 1ns/1ps
module sync_rx_model (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic wantDed,
  input  wire logic wantTs,
  output logic      dedPin_n,
  output logic      tsPin_n
);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dedPin_n <= 1'b1;
      tsPin_n  <= 1'b1;
    end else begin
      dedPin_n <= !wantDed;
      tsPin_n  <= !wantTs;
    end
  end
endmodule : sync_rx_model

// file: sim/testbench.sv
// Purpose: Self-checking bench for the link config bank
// Assumes: One-wait-state slave, byte address is four times the index
// Notes:   Outputs are read a few edges after a write, as they follow the registers
`timescale 1ns/1ps
module testbench;
  import serial_link_cfg_pkg::*;
  logic        clk = 0, reset_n = 0, read = 0, write = 0, tsEn = 1, wantDed = 0, wantTs = 0;
  logic [13:0] address = '0;
  logic [31:0] writedata = '0, readdata, rd;
  logic [3:0]  byteenable = 4'hf;
  logic [7:0]  laneA, laneB, mfEnc = 8'h00;
  logic [8:0]  mfCount, mx;
  logic [4:0]  testSel;
  logic        waitrequest, dedPin_n, tsPin_n, syncReq, scrAct, holdLink, mfStart, enc66b;
  sample_fmt_t sampleFormat;
  int          n_errors = 0, num_checks = 0;
  always #50 clk = ~clk;
  serial_link_config_registers dut_u (.clk(clk), .reset_n(reset_n), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .dedicatedSyncInput_n(dedPin_n),
    .timestampInput_n(tsPin_n), .timestampReceiverEnable(tsEn), .framesPerMfEncoded(mfEnc),
    .syncRequest(syncReq), .scramblerActive(scrAct), .sampleFormat(sampleFormat),
    .linkTestSelect(testSel), .laneEnableA(laneA), .laneEnableB(laneB),
    .linkResetHold(holdLink), .multiframeCount(mfCount), .multiframeStart(mfStart),
    .enc66bActive(enc66b));
  sync_rx_model far_u (.clk(clk), .reset_n(reset_n), .wantDed(wantDed), .wantTs(wantTs),
    .dedPin_n(dedPin_n), .tsPin_n(tsPin_n));
  task automatic ck(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : ck
  task automatic bus(input logic w, input logic [11:0] i, input logic [7:0] d);
    @(posedge clk);
    address   <= {i, 2'b00};
    writedata <= {24'h0, d};
    read      <= !w;
    write     <= w;
    do @(posedge clk); while (waitrequest !== 1'b0);
    rd = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic st;
    repeat (4) @(posedge clk);
  endtask : st
  task automatic t_resets;
    logic [7:0] ev [4] = '{8'h1f, 8'h01, 8'h03, 8'h00};
    for (int k = 0; k < 4; k++) begin
      bus(0, 12'h202 + 12'(k), 8'h0);
      ck("reset value", rd, {24'h0, ev[k]});
    end
    ck("lanes A", laneA, 8'h0f);
    ck("format", sampleFormat, 1'b1);
    ck("scrambler", scrAct, 1'b1);
  endtask : t_resets
  task automatic t_regs;
    bus(1, 12'h200, 8'h00);
    st;
    ck("hold", holdLink, 1'b1);
    bus(1, 12'h202, 8'h03);
    bus(0, 12'h202, 8'h0);
    ck("length", rd, 32'h3);
    byteenable <= 4'h0;
    bus(1, 12'h202, 8'h05);
    byteenable <= 4'hf;
    bus(0, 12'h202, 8'h0);
    ck("byte lane off", rd, 32'h3);
    bus(1, 12'h204, 8'h1c);
    bus(0, 12'h0fc, 8'h0);
    ck("unmapped", rd, 32'h0);
    bus(1, 12'h200, 8'h01);
    st;
    ck("upper lanes B", laneB, 8'hf0);
    ck("offset binary", sampleFormat, 1'b0);
    ck("scrambler off", scrAct, 1'b0);
    mx = '0;
    repeat (12) @(posedge clk) if (mfCount > mx) mx = mfCount;
    ck("frame max", mx, 32'h3);
    bus(1, 12'h200, 8'h00);
    bus(1, 12'h201, 8'h14);
    bus(1, 12'h200, 8'h01);
    repeat (12) @(posedge clk);
    ck("66b scramble", scrAct, 1'b1);
    ck("66b frames", mfCount > 9'h3, 1'b1);
  endtask : t_regs
  task automatic t_sync;
    logic [1:0] sel [6] = '{2'h0, 2'h2, 2'h1, 2'h0, 2'h2, 2'h1};
    logic [4:0] pd [6] = '{5'b11, 5'b10, 5'b01, 5'b00, 5'b00, 5'b01};
    logic [4:0] sw [6] = '{5'b1, 5'b1, 5'b1, 5'b0, 5'b0, 5'b1};
    logic [4:0] ex [6] = '{5'b1, 5'b0, 5'b1, 5'b1, 5'b1, 5'b0};
    logic       te [6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    for (int k = 0; k < 6; k++) begin
      wantDed <= pd[k][1];
      wantTs  <= pd[k][0];
      tsEn    <= te[k];
      bus(1, 12'h200, 8'h00);
      bus(1, 12'h204, {4'h0, sel[k], 2'b11});
      bus(1, 12'h200, 8'h01);
      bus(1, 12'h203, {7'h0, sw[k][0]});
      st;
      ck("sync request", syncReq, ex[k][0]);
    end
  endtask : t_sync
  task automatic results;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    results;
  end
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    t_resets;
    t_regs;
    t_sync;
    results;
  end
endmodule : testbench
